// >>> design/channel_sequencer.sv
// Counts filter samples of one channel and flags each new result once the first-event sample count is reached
module channel_sequencer (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 run,
    input  wire logic [1:0]           first_irq_delay,
    input  wire sd_conv_pkg::sample_s sample,
    output logic [31:0]               result_word,
    output logic                      result_event
);

    sd_conv_pkg::seq_state_e state;
    sd_conv_pkg::seq_state_e next_state;
    logic [2:0]                count;
    logic [2:0]                next_count;
    logic [2:0]                need;
    logic [31:0]               next_result_word;
    logic                      next_result_event;

    // ------------------------------------------------------------------
    // Sample sequencing
    // ------------------------------------------------------------------
    // Code 00 waits for the fourth sample, 11 takes the first; dropping
    // the early samples hides the filter settling time.
    always_comb begin
        need              = sd_conv_pkg::SAMPLES_MAX - {1'b0, first_irq_delay};
        next_state        = state;
        next_count        = count;
        next_result_word  = result_word;
        next_result_event = 1'b0;
        case (state)
            sd_conv_pkg::SEQ_IDLE: begin
                next_count = 3'h0;
                if (run) begin
                    next_state = sd_conv_pkg::SEQ_FIRST;
                end
            end
            sd_conv_pkg::SEQ_FIRST: begin
                if (!run) begin
                    next_state = sd_conv_pkg::SEQ_IDLE;
                end else if (sample.valid) begin
                    next_count       = count + 3'h1;
                    next_result_word = sample.data;
                    if (count + 3'h1 >= need) begin
                        next_state        = sd_conv_pkg::SEQ_EVERY;
                        next_result_event = 1'b1;
                    end
                end
            end
            sd_conv_pkg::SEQ_EVERY: begin
                if (!run) begin
                    next_state = sd_conv_pkg::SEQ_IDLE;
                end else if (sample.valid) begin
                    next_result_word  = sample.data;
                    next_result_event = 1'b1;
                end
            end
            default: begin
                next_state = sd_conv_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= sd_conv_pkg::SEQ_IDLE;
            count        <= 3'h0;
            result_word  <= 32'h0000_0000;
            result_event <= 1'b0;
        end else begin
            state        <= next_state;
            count        <= next_count;
            result_word  <= next_result_word;
            result_event <= next_result_event;
        end
    end

endmodule // channel_sequencer

// >>> design/sd_conv_pkg.sv
package sd_conv_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHAN   = 7;
    localparam int RESULT_W   = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_ANALOG_EN  = 12'h000;
    localparam logic [11:0] OFF_VECTOR     = 12'h004;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK   = 12'h00c;
    localparam logic [11:0] OFF_CHAN_BASE  = 12'h010;
    localparam logic [11:0] OFF_CHAN_LAST  = 12'h07c;
    // Offsets inside one channel block of 16 bytes
    localparam logic [3:0]  SUB_CHAN_CTL   = 4'h0;
    localparam logic [3:0]  SUB_INPUT_CTL  = 4'h4;
    localparam logic [3:0]  SUB_PRELOAD    = 4'h8;
    localparam logic [3:0]  SUB_RESULT     = 4'hc;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_RUN_BIT      = 0;
    localparam int CTL_LOW_HALF_BIT = 1;
    localparam int INCTL_PAIR_LSB   = 0;
    localparam int INCTL_GAIN_LSB   = 3;
    localparam int INCTL_DELAY_LSB  = 6;
    localparam int STAT_READY_LSB   = 0;
    localparam int STAT_OVF_LSB     = 8;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_HALF       = 16'h0000;
    localparam logic [1:0]  RST_CTL        = 2'h0;
    localparam logic [2:0]  GAIN_LAST_OK   = 3'h5;
    localparam logic [15:0] VEC_NONE       = 16'h0000;
    localparam logic [15:0] VEC_OVERFLOW   = 16'h0002;
    localparam logic [15:0] VEC_CHAN0      = 16'h0004;
    localparam logic [2:0]  SAMPLES_MAX    = 3'h4;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                valid;
        logic [RESULT_W-1:0] data;
    } sample_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_FIRST,
        SEQ_EVERY
    } seq_state_e;

endpackage

// >>> design/sigma_delta_adc_channel_regs.sv
// Notes on behaviour
// - Result register returns upper or lower filter half per low-half select.
// - Ready flag sets on new result; clears on result read or software clear.
// - Eight-bit preload per channel feeds the filter, resets to zero.
// - Analog enable bit clear isolates that input and grounds its negative side.
// - Vector reads 000h when idle and 002h whenever any overflow is pending.
// - Ready on channel n reads 004h plus 2n; lower channel wins.
module sigma_delta_adc_channel_regs (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    output logic                             irq,
    // Filter side
    input  wire sd_conv_pkg::sample_s [6:0]  sample,
    output logic [6:0]                       conversion_run,
    output logic [6:0][2:0]                  preamp_gain_sel,
    output logic [6:0][2:0]                  input_pair_sel,
    output logic [6:0][7:0]                  filter_preload,
    output logic [7:0]                       analog_input_en
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [6:0][1:0]  chan_ctl;
    logic [6:0][1:0]  next_chan_ctl;
    logic [6:0][7:0]  in_ctl;
    logic [6:0][7:0]  next_in_ctl;
    logic [6:0][7:0]  next_filter_preload;
    logic [7:0]       next_analog_input_en;
    logic [15:0]      irq_status;
    logic [15:0]      next_irq_status;
    logic [15:0]      irq_mask;
    logic [15:0]      next_irq_mask;
    logic             next_pready;
    logic [31:0]      next_prdata;
    logic             next_pslverr;
    logic             next_irq;
    logic [6:0][31:0] result_word;
    logic [6:0]       result_event;
    logic [15:0]      vector_code;
    logic             wr_access;
    logic             rd_access;
    logic             setup;
    logic [6:0]       ready_flags;
    logic [6:0]       overflow_flags;

    // ------------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------------
    function automatic logic in_chan_block(input logic [11:0] a);
        return (a >= sd_conv_pkg::OFF_CHAN_BASE) && (a <= sd_conv_pkg::OFF_CHAN_LAST)
               && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] chan_of(input logic [11:0] a);
        logic [11:0] rel;
        rel = a - sd_conv_pkg::OFF_CHAN_BASE;
        return rel[6:4];
    endfunction

    function automatic logic [15:0] result_half(input logic [31:0] w, input logic low);
        return low ? w[15:0] : w[31:16];
    endfunction

    // ------------------------------------------------------------------
    // Channel sequencers and vector encoder
    // ------------------------------------------------------------------
    for (genvar g = 0; g < sd_conv_pkg::NUM_CHAN; g++) begin : g_chan
        channel_sequencer u_seq (
            .pclk            (pclk),
            .presetn         (presetn),
            .run             (chan_ctl[g][sd_conv_pkg::CTL_RUN_BIT]),
            .first_irq_delay (in_ctl[g][sd_conv_pkg::INCTL_DELAY_LSB +: 2]),
            .sample          (sample[g]),
            .result_word     (result_word[g]),
            .result_event    (result_event[g])
        );
        assign preamp_gain_sel[g] = in_ctl[g][sd_conv_pkg::INCTL_GAIN_LSB +: 3];
        assign input_pair_sel[g]  = in_ctl[g][sd_conv_pkg::INCTL_PAIR_LSB +: 3];
        assign conversion_run[g]  = chan_ctl[g][sd_conv_pkg::CTL_RUN_BIT];
    end

    assign ready_flags    = irq_status[sd_conv_pkg::STAT_READY_LSB +: 7];
    assign overflow_flags = irq_status[sd_conv_pkg::STAT_OVF_LSB +: 7];

    vector_encoder u_vec (
        .ready_flags    (ready_flags),
        .overflow_flags (overflow_flags),
        .vector_code    (vector_code)
    );

    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    // Zero wait states: pready rises for the first access cycle
    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;
    assign rd_access = psel && penable && pready && !pwrite;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0] ch;
        logic [3:0] sub;
        ch                   = chan_of(paddr);
        sub                  = paddr[3:0];
        next_chan_ctl        = chan_ctl;
        next_in_ctl          = in_ctl;
        next_filter_preload  = filter_preload;
        next_analog_input_en = analog_input_en;
        next_irq_mask        = irq_mask;
        if (wr_access) begin
            if (paddr == sd_conv_pkg::OFF_ANALOG_EN) begin
                next_analog_input_en = pwdata[7:0];
            end
            if (paddr == sd_conv_pkg::OFF_IRQ_MASK) begin
                next_irq_mask = pwdata[15:0];
            end
            if (in_chan_block(paddr)) begin
                case (sub)
                    sd_conv_pkg::SUB_CHAN_CTL: begin
                        next_chan_ctl[ch] = pwdata[1:0];
                    end
                    sd_conv_pkg::SUB_INPUT_CTL: begin
                        next_in_ctl[ch] = pwdata[7:0];
                        // Reserved gain codes would drive the amplifier off
                        // its characterised range, so the old gain is kept
                        if (pwdata[sd_conv_pkg::INCTL_GAIN_LSB +: 3]
                                > sd_conv_pkg::GAIN_LAST_OK) begin
                            next_in_ctl[ch][sd_conv_pkg::INCTL_GAIN_LSB +: 3] =
                                in_ctl[ch][sd_conv_pkg::INCTL_GAIN_LSB +: 3];
                        end
                    end
                    sd_conv_pkg::SUB_PRELOAD: begin
                        next_filter_preload[ch] = pwdata[7:0];
                    end
                    default: begin
                        next_chan_ctl = chan_ctl;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_ctl        <= {sd_conv_pkg::NUM_CHAN{sd_conv_pkg::RST_CTL}};
            in_ctl          <= {sd_conv_pkg::NUM_CHAN{sd_conv_pkg::RST_BYTE}};
            filter_preload  <= {sd_conv_pkg::NUM_CHAN{sd_conv_pkg::RST_BYTE}};
            analog_input_en <= sd_conv_pkg::RST_BYTE;
            irq_mask        <= sd_conv_pkg::RST_HALF;
        end else begin
            chan_ctl        <= next_chan_ctl;
            in_ctl          <= next_in_ctl;
            filter_preload  <= next_filter_preload;
            analog_input_en <= next_analog_input_en;
            irq_mask        <= next_irq_mask;
        end
    end

    // ------------------------------------------------------------------
    // Sticky status flags and interrupt line
    // ------------------------------------------------------------------
    // Clears are applied first so that an event in the same cycle wins.
    // A result landing on an unread one is an overflow; the old value is lost.
    always_comb begin
        next_irq_status = irq_status;
        if (wr_access && paddr == sd_conv_pkg::OFF_IRQ_STATUS) begin
            next_irq_status = irq_status & ~pwdata[15:0];
        end
        if (rd_access && in_chan_block(paddr) && paddr[3:0] == sd_conv_pkg::SUB_RESULT) begin
            next_irq_status[sd_conv_pkg::STAT_READY_LSB + chan_of(paddr)] = 1'b0;
        end
        for (int n = 0; n < sd_conv_pkg::NUM_CHAN; n++) begin
            if (result_event[n]) begin
                next_irq_status[sd_conv_pkg::STAT_READY_LSB + n] = 1'b1;
                if (irq_status[sd_conv_pkg::STAT_READY_LSB + n]) begin
                    next_irq_status[sd_conv_pkg::STAT_OVF_LSB + n] = 1'b1;
                end
            end
        end
        next_irq_status[7]  = 1'b0;
        next_irq_status[15] = 1'b0;
        next_irq = |(next_irq_status & irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= sd_conv_pkg::RST_HALF;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Read path and bus answer
    // ------------------------------------------------------------------
    // Read data is sampled at the setup edge and held through the access.
    always_comb begin
        logic [2:0] ch;
        ch           = chan_of(paddr);
        next_pready  = setup;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (setup) begin
            next_prdata  = 32'h0000_0000;
            next_pslverr = 1'b0;
            if (paddr == sd_conv_pkg::OFF_ANALOG_EN) begin
                next_prdata[7:0] = analog_input_en;
            end else if (paddr == sd_conv_pkg::OFF_VECTOR) begin
                next_prdata[15:0] = vector_code;
                next_pslverr      = pwrite;
            end else if (paddr == sd_conv_pkg::OFF_IRQ_STATUS) begin
                next_prdata[15:0] = irq_status;
            end else if (paddr == sd_conv_pkg::OFF_IRQ_MASK) begin
                next_prdata[15:0] = irq_mask;
            end else if (in_chan_block(paddr)) begin
                case (paddr[3:0])
                    sd_conv_pkg::SUB_CHAN_CTL: begin
                        next_prdata[1:0] = chan_ctl[ch];
                    end
                    sd_conv_pkg::SUB_INPUT_CTL: begin
                        next_prdata[7:0] = in_ctl[ch];
                    end
                    sd_conv_pkg::SUB_PRELOAD: begin
                        next_prdata[7:0] = filter_preload[ch];
                    end
                    sd_conv_pkg::SUB_RESULT: begin
                        next_prdata[15:0] = result_half(result_word[ch],
                            chan_ctl[ch][sd_conv_pkg::CTL_LOW_HALF_BIT]);
                        next_pslverr = pwrite;
                    end
                    default: begin
                        next_pslverr = 1'b1;
                    end
                endcase
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule // sigma_delta_adc_channel_regs

// >>> design/vector_encoder.sv
// Priority encoder for the interrupt vector; purely combinational
module vector_encoder (
    input  wire logic [6:0]  ready_flags,
    input  wire logic [6:0]  overflow_flags,
    output logic [15:0]      vector_code
);

    // Overflow first, then the lowest channel with a result pending
    function automatic logic [15:0] encode(input logic [6:0] rdy, input logic [6:0] ovf);
        logic [15:0] v;
        v = sd_conv_pkg::VEC_NONE;
        for (int n = sd_conv_pkg::NUM_CHAN - 1; n >= 0; n--) begin
            if (rdy[n]) begin
                v = sd_conv_pkg::VEC_CHAN0 + 16'(2 * n);
            end
        end
        if (|ovf) begin
            v = sd_conv_pkg::VEC_OVERFLOW;
        end
        return v;
    endfunction

    // Bits 4:1 only can be nonzero by construction
    always_comb begin
        vector_code = encode(ready_flags, overflow_flags);
    end

endmodule // vector_encoder

// >>> tb/sigma_delta_adc_channel_regs_properties.sv
module sigma_delta_adc_channel_regs_properties (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [11:0]                 paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic                        pready,
    input wire logic [31:0]                 prdata,
    input wire logic                        pslverr,
    input wire logic                        irq,
    input wire sd_conv_pkg::sample_s [6:0]  sample,
    input wire logic [6:0]                  conversion_run,
    input wire logic [6:0][2:0]             preamp_gain_sel,
    input wire logic [6:0][2:0]             input_pair_sel,
    input wire logic [6:0][7:0]             filter_preload,
    input wire logic [7:0]                  analog_input_en
);
    // ----------------------------------------------------------------
    // Bus handshake and register effects, all on the one clock
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // An answer longer than one cycle would complete a second transfer
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stayed high past one cycle");
    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("access cycle without pready");
    err_timing_a: assert property (pslverr |-> pready)
        else $error("pslverr outside the answer cycle");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    vector_bits_a: assert property (
        pready && !pwrite && paddr == 12'h004 |-> prdata[31:5] == 27'h0 && !prdata[0]
        && prdata[4:1] <= 4'h8) else $error("vector read outside its code field");
    enable_write_a: assert property (
        psel && penable && pready && pwrite && paddr == 12'h000
        |=> analog_input_en == $past(pwdata[7:0])) else $error("analog enable not written");
    preload_write_a: assert property (
        psel && penable && pready && pwrite && paddr == 12'h018
        |=> filter_preload[0] == $past(pwdata[7:0])) else $error("preload not written");
    gain_reserved_a: assert property (
        psel && penable && pready && pwrite && paddr == 12'h014 && pwdata[5:3] > 3'h5
        |=> $stable(preamp_gain_sel[0])) else $error("reserved gain code took effect");
    gain_take_a: assert property (
        psel && penable && pready && pwrite && paddr == 12'h014 && pwdata[5:3] <= 3'h5
        |=> preamp_gain_sel[0] == $past(pwdata[5:3])) else $error("gain code not taken");
endmodule // sigma_delta_adc_channel_regs_properties

bind sigma_delta_adc_channel_regs sigma_delta_adc_channel_regs_properties
    sigma_delta_adc_channel_regs_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .sample(sample), .conversion_run(conversion_run),
    .preamp_gain_sel(preamp_gain_sel), .input_pair_sel(input_pair_sel),
    .filter_preload(filter_preload), .analog_input_en(analog_input_en));

// >>> tb/sigma_delta_adc_channel_regs_tb.sv
module sigma_delta_adc_channel_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0]                paddr;
    logic [31:0]                pwdata, prdata, rd, seed, v, d;
    sd_conv_pkg::sample_s [6:0] smp;
    logic [6:0]                 conversion_run;
    logic [6:0][2:0]            preamp_gain_sel, input_pair_sel;
    logic [6:0][7:0]            filter_preload;
    logic [7:0]                 analog_input_en;
    int                         fails, checks_done, n, k, c;

    sigma_delta_adc_channel_regs sigma_delta_adc_channel_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .sample(smp), .conversion_run(conversion_run),
        .preamp_gain_sel(preamp_gain_sel), .input_pair_sel(input_pair_sel),
        .filter_preload(filter_preload), .analog_input_en(analog_input_en));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [11:0] ca(input int ch, input int sub);
        return 12'(16 + 16 * ch + sub);
    endfunction
    // One idle edge first, so psel is never assigned twice in one step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20) begin
            fails++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(what, rd, exp);
    endtask
    // Data is inverted once valid drops so a stale word never looks fresh
    task automatic pulse(input int ch, input logic [31:0] dat);
        @(posedge pclk);
        smp[ch] <= '{valid: 1'b1, data: dat};
        @(posedge pclk);
        smp[ch] <= '{valid: 1'b0, data: ~dat};
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        smp = '0;
        seed = 32'h118c45c3;
        fails = 0;
        checks_done = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("analog_enable", 12'h000, 32'h0);
        rdchk("vector_idle", 12'h004, 32'h0);
        for (n = 0; n < 7; n++) begin
            rdchk("input_ctl_reset", ca(n, 4), 32'h0);
            rdchk("preload_reset", ca(n, 8), 32'h0);
        end
        apb(12'h080, 1'b0, 32'h0);
        check("unmapped_err", 32'(err), 32'h1);
        apb(12'h004, 1'b1, 32'hff);
        check("vector_write_err", 32'(err), 32'h1);
        v = lfsr();
        apb(12'h000, 1'b1, v);
        check("analog_port", 32'(analog_input_en), 32'(v[7:0]));
        rdchk("analog_back", 12'h000, 32'(v[7:0]));
        // Every gain code, random pair and delay fields, then a reserved gain
        for (n = 0; n < 7; n++) begin
            d = lfsr();
            d[5:3] = 3'(n % 6);
            apb(ca(n, 4), 1'b1, 32'(d[7:0]));
            check("gain_port", 32'(preamp_gain_sel[n]), 32'(n % 6));
            check("pair_port", 32'(input_pair_sel[n]), 32'(d[2:0]));
            apb(ca(n, 4), 1'b1, 32'({d[7:6], 3'h6 + 3'(n % 2), d[2:0]}));
            rdchk("gain_kept", ca(n, 4), 32'(d[7:0]));
            v = lfsr();
            apb(ca(n, 8), 1'b1, 32'(v[7:0]));
            check("preload_port", 32'(filter_preload[n]), 32'(v[7:0]));
        end
        // First event after 4, 3, 2 and 1 samples
        for (c = 0; c < 4; c++) begin
            apb(ca(1, 4), 1'b1, 32'({c[1:0], 6'h0}));
            apb(ca(1, 0), 1'b1, 32'h1);
            check("run_port", 32'(conversion_run), 32'h2);
            for (k = 1; k <= 4 - c; k++) begin
                d = lfsr();
                pulse(1, d);
                apb(12'h008, 1'b0, 32'h0);
                check("ready_bit", 32'(rd[1]), 32'(k == 4 - c));
            end
            rdchk("result_hi", ca(1, 12), 32'(d[31:16]));
            rdchk("read_clears", 12'h008, 32'h0);
            apb(ca(1, 0), 1'b1, 32'h0);
        end
        apb(ca(1, 0), 1'b1, 32'h3);
        d = lfsr();
        pulse(1, d);
        rdchk("result_lo", ca(1, 12), 32'(d[15:0]));
        pulse(1, lfsr());
        apb(12'h008, 1'b1, 32'h2);
        rdchk("sw_clear", 12'h008, 32'h0);
        // Vector priority over all channels, then an overflow
        apb(12'h00c, 1'b1, 32'h0);
        for (n = 0; n < 7; n++) apb(ca(n, 4), 1'b1, 32'hc0);
        for (n = 0; n < 7; n++) apb(ca(n, 0), 1'b1, 32'h1);
        for (n = 6; n >= 0; n--) begin
            pulse(n, lfsr());
            rdchk("vector_chan", 12'h004, 32'(4 + 2 * n));
        end
        check("irq_masked", 32'(irq), 32'h0);
        apb(12'h00c, 1'b1, 32'h7fff);
        @(negedge pclk);
        check("irq_unmasked", 32'(irq), 32'h1);
        pulse(3, lfsr());
        rdchk("vector_ovf", 12'h004, 32'h2);
        rdchk("status_scan", 12'h008, 32'h87f);
        apb(12'h008, 1'b1, 32'h7fff);
        rdchk("vector_clear", 12'h004, 32'h0);
        check("irq_cleared", 32'(irq), 32'h0);
        finish_test();
    end
endmodule // sigma_delta_adc_channel_regs_tb
